// ==== design/tcm_ctrl.v ====
`include "tcm_defs.vh"

module tcm_ctrl (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  input wire standby,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // timer event from channel 1, same clock
  input wire capture_a_ch1,
  // raw timer outputs from the channel logic
  input wire [5:0] timer_out,
  // gated outputs: pin_a_ch3, pin_a_ch4, pin_b_ch4, pin_b_ch3,
  // pin_extra_a_ch4, pin_extra_b_ch4 at bits 0..5
  output reg [5:0] pin_out,
  output reg [5:0] pin_out_en,
  // decoded mode to the counters
  output reg complementary_pwm,
  output reg reset_sync_pwm,
  output reg pwm_sel_ch3,
  output reg pwm_sel_ch4,
  output reg sync_ch3,
  output reg sync_ch4,
  output reg [3:0] buffer_en
);

  reg [7:0] function_control_register_r;
  reg [7:0] output_master_enable_register_r;
  reg [7:0] ctl_r;
  reg [`TCM_AW-1:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg have_aw_r;
  reg have_w_r;
  reg waddr_hi_ok_r;
  reg trig_clear;
  reg combo_on;
  reg wr_fire;
  reg [7:0] fcr_nxt;
  reg [7:0] oer_nxt;
  reg [7:0] ctl_nxt;

  // word-aligned decode of a register address
  function valid_addr;
    input [`TCM_AW-1:0] a;
    begin
      valid_addr = (a == `TCM_ADDR_FCR) || (a == `TCM_ADDR_OER) ||
                   (a == `TCM_ADDR_CTL) || (a == `TCM_ADDR_STS);
    end
  endfunction

  function [31:0] read_word;
    input [`TCM_AW-1:0] a;
    input [7:0] fcr;
    input [7:0] oer;
    input [7:0] ctl;
    input [5:0] en;
    begin
      case (a)
        `TCM_ADDR_FCR: read_word = {24'h00_0000, fcr};
        `TCM_ADDR_OER: read_word = {24'h00_0000, oer};
        `TCM_ADDR_CTL: read_word = {24'h00_0000, ctl};
        `TCM_ADDR_STS: read_word = {26'h000_0000, en};
        default: read_word = 32'h0000_0000;
      endcase
    end
  endfunction

  always @* begin
    combo_on = function_control_register_r[`TCM_CMD_HI];
    // trigger only counts in a combination mode
    trig_clear = capture_a_ch1 && combo_on &&
                 !ctl_r[`TCM_CTL_EXT_TRIGGER_DISABLE];
    wr_fire = have_aw_r && have_w_r && !s_axi_bvalid;
    fcr_nxt = function_control_register_r;
    oer_nxt = output_master_enable_register_r;
    ctl_nxt = ctl_r;
    // unmapped upper address bits leave every register untouched
    if (wr_fire && wstrb_r[0] && waddr_hi_ok_r) begin
      case (waddr_r)
        `TCM_ADDR_FCR: fcr_nxt = wdata_r[7:0] | `TCM_RO_ONES;
        `TCM_ADDR_OER: oer_nxt = wdata_r[7:0] | `TCM_RO_ONES;
        `TCM_ADDR_CTL:
          ctl_nxt = {3'b000, wdata_r[`TCM_CTL_W-1:0]};
        default: ctl_nxt = ctl_r;
      endcase
    end
    // hardware clear applied last so it wins
    if (trig_clear)
      oer_nxt = `TCM_OER_CLR;
  end

  // register file; standby behaves as reset
  always @(posedge aclk) begin
    if (!aresetn || standby) begin
      function_control_register_r <= `TCM_FCR_RST;
      output_master_enable_register_r <= `TCM_OER_RST;
      ctl_r <= `TCM_CTL_RST;
    end else begin
      function_control_register_r <= fcr_nxt;
      output_master_enable_register_r <= oer_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  // write channels, taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCM_RESP_OKAY;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      waddr_r <= {`TCM_AW{1'b0}};
      waddr_hi_ok_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      s_axi_awready <= !have_aw_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !have_w_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_r <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_r <= s_axi_awaddr[`TCM_AW-1:0];
        waddr_hi_ok_r <= (s_axi_awaddr[31:`TCM_AW] == 28'h000_0000);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        have_aw_r <= 1'b0;
        have_w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // upper address bits must be zero as well
        s_axi_bresp <= (valid_addr(waddr_r) && waddr_hi_ok_r) ?
                       `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one outstanding read
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TCM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word(s_axi_araddr[`TCM_AW-1:0],
                                 function_control_register_r,
                                 output_master_enable_register_r, ctl_r,
                                 pin_out_en);
        s_axi_rresp <= (valid_addr(s_axi_araddr[`TCM_AW-1:0]) &&
                        s_axi_araddr[31:`TCM_AW] == 28'h000_0000) ?
                       `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // registered pin gating and mode outputs
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_pin
      always @(posedge aclk) begin
        if (!aresetn) begin
          pin_out[gi] <= 1'b0;
          pin_out_en[gi] <= 1'b0;
        end else begin
          // zero enable leaves the pin to general i/o
          pin_out_en[gi] <=
            output_master_enable_register_r[gi];
          pin_out[gi] <= timer_out[gi] &
                         output_master_enable_register_r[gi];
        end
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      complementary_pwm <= 1'b0;
      reset_sync_pwm <= 1'b0;
      pwm_sel_ch3 <= 1'b0;
      pwm_sel_ch4 <= 1'b0;
      sync_ch3 <= 1'b0;
      sync_ch4 <= 1'b0;
      buffer_en <= 4'h0;
    end else begin
      complementary_pwm <= combo_on &&
        !function_control_register_r[`TCM_CMD_LO];
      reset_sync_pwm <= combo_on &&
        function_control_register_r[`TCM_CMD_LO];
      pwm_sel_ch3 <= ctl_r[`TCM_CTL_PWM_SEL_CH3] && !combo_on;
      pwm_sel_ch4 <= ctl_r[`TCM_CTL_PWM_SEL_CH4] && !combo_on;
      sync_ch3 <= ctl_r[`TCM_CTL_SYNC_CH3];
      sync_ch4 <= ctl_r[`TCM_CTL_SYNC_CH4];
      buffer_en <= function_control_register_r[3:0];
    end
  end

endmodule

// ==== include/tcm_defs.vh ====
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH

// register byte addresses
`define TCM_ADDR_FCR 4'h0
`define TCM_ADDR_OER 4'h4
`define TCM_ADDR_CTL 4'h8
`define TCM_ADDR_STS 4'hC
`define TCM_AW 4

// reset values, read-only ones mask and trigger clear value
`define TCM_FCR_RST 8'hC0
`define TCM_OER_RST 8'hFF
`define TCM_CTL_RST 8'h01
`define TCM_RO_ONES 8'hC0
`define TCM_OER_CLR 8'hC0

// field positions
`define TCM_CMD_HI 5
`define TCM_CMD_LO 4
`define TCM_CTL_EXT_TRIGGER_DISABLE 0
`define TCM_CTL_PWM_SEL_CH3 1
`define TCM_CTL_PWM_SEL_CH4 2
`define TCM_CTL_SYNC_CH3 3
`define TCM_CTL_SYNC_CH4 4
`define TCM_CTL_W 5

// axi responses
`define TCM_RESP_OKAY 2'b00
`define TCM_RESP_SLVERR 2'b10

`endif

// ==== test/tb_tcm_ctrl.sv ====
`include "tcm_defs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb_tcm_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FCR = 32'(`TCM_ADDR_FCR);
  localparam logic [31:0] OER = 32'(`TCM_ADDR_OER);
  localparam logic [31:0] CTL = 32'(`TCM_ADDR_CTL);
  localparam logic [31:0] STS = 32'(`TCM_ADDR_STS);
  logic aclk = 0, aresetn = 0, standby = 0, capture_a_ch1 = 0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [5:0] timer_out = 6'h3f;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [5:0] pin_out, pin_out_en;
  wire complementary_pwm, reset_sync_pwm, pwm_sel_ch3, pwm_sel_ch4;
  wire sync_ch3, sync_ch4;
  wire [3:0] buffer_en;
  int err_count = 0, checked = 0, cyc = 0;
  logic [1:0] r;
  logic [7:0] d;
  tcm_ctrl tcm_ctrl_i (.*);
  initial forever #10 aclk = ~aclk;
  task automatic final_report;
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      final_report;
    end
  end
  task automatic wr(input logic [31:0] a, input logic [7:0] v,
                    input bit clash = 0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      // trigger lands on the edge that commits the write
      capture_a_ch1 <= clash && s_axi_awready && s_axi_wready;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic chk_rd(input logic [31:0] a, input logic [7:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  task automatic pulse;
    @(posedge aclk);
    capture_a_ch1 <= 1;
    @(posedge aclk);
    capture_a_ch1 <= 0;
  endtask
  task automatic t_reset_vals;
    chk_rd(FCR, 8'hc0);
    chk_rd(OER, 8'hff);
    chk_rd(CTL, 8'h01);
  endtask
  task automatic t_modes;
    // timer_out held static: counters stopped before mode change
    wr(CTL, 8'h0e);
    chk_rd(CTL, 8'h0e);
    for (int i = 0; i < 4; i++) begin
      wr(FCR, 8'(i * 16 + (1 << i)));
      repeat (2) @(posedge aclk);
      `CHK(complementary_pwm, i == 2)
      `CHK(reset_sync_pwm, i == 3)
      `CHK(pwm_sel_ch3, i < 2)
      `CHK(pwm_sel_ch4, i < 2)
      `CHK(sync_ch3, 1'b1)
      `CHK(sync_ch4, 1'b0)
      `CHK(buffer_en, 4'(1 << i))
      chk_rd(FCR, 8'(192 + i * 16 + (1 << i)));
    end
  endtask
  task automatic t_gate;
    wr(OER, 8'h15);
    repeat (2) @(posedge aclk);
    `CHK(pin_out, 6'h15)
    `CHK(pin_out_en, 6'h15)
    chk_rd(OER, 8'hd5);
    chk_rd(STS, 8'h15);
    timer_out <= 6'h2a;
    repeat (3) @(posedge aclk);
    `CHK(pin_out, 6'h00)
  endtask
  task automatic t_trig;
    wr(FCR, 8'h00);
    wr(OER, 8'hff);
    pulse;
    chk_rd(OER, 8'hff);
    wr(FCR, 8'h20);
    pulse;
    chk_rd(OER, 8'hc0);
    `CHK(pin_out_en, 6'h00)
    wr(CTL, 8'h0f);
    wr(OER, 8'hff);
    pulse;
    chk_rd(OER, 8'hff);
    wr(CTL, 8'h0e);
    wr(OER, 8'hff, 1);
    chk_rd(OER, 8'hc0);
  endtask
  task automatic t_unmapped;
    wr(32'h0000_0010, 8'h00);
    `CHK(r, `TCM_RESP_SLVERR)
    chk_rd(FCR, 8'he0);
    rd(32'h0000_0010);
    `CHK(r, `TCM_RESP_SLVERR)
  endtask
  task automatic t_standby;
    wr(FCR, 8'h2a);
    @(posedge aclk);
    standby <= 1;
    repeat (2) @(posedge aclk);
    standby <= 0;
    t_reset_vals;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    t_reset_vals;
    t_modes;
    t_gate;
    t_trig;
    t_unmapped;
    t_standby;
    final_report;
  end
endmodule

// ==== test/tcm_ctrl_properties.sv ====
module tcm_ctrl_properties (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // timer side
  input wire [5:0] timer_out,
  input wire [5:0] pin_out,
  input wire [5:0] pin_out_en,
  input wire complementary_pwm,
  input wire reset_sync_pwm,
  input wire pwm_sel_ch3,
  input wire pwm_sel_ch4
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_EN_RST:
    assert property ($rose(aresetn) |=> pin_out_en == 6'h3f)
    else $error("enables not on after reset");
  AST_GATE:
    assert property (pin_out == ($past(timer_out) & pin_out_en))
    else $error("pin gating wrong");
  AST_MODE_EXCL:
    assert property (!(complementary_pwm && reset_sync_pwm))
    else $error("two combination modes at once");
  AST_PWM_OVR:
    assert property ((complementary_pwm || reset_sync_pwm) |->
      !pwm_sel_ch3 && !pwm_sel_ch4) else $error("pwm select not overridden");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  AST_W_BLOCK:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_R_ANS:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind tcm_ctrl tcm_ctrl_properties tcm_ctrl_properties_i (.*);
